// file: hw/dsc_pkg.sv
package dsc_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int FN_W = 6;
  localparam int GROUPS = 5;
  localparam int TIMER_W = 14;

  localparam logic [5:0] FN_NOP = 6'h00;
  localparam logic [5:0] FN_CLR_CODE = 6'h01;
  localparam logic [5:0] FN_SOFT_CLEAR_CMD = 6'h02;
  localparam logic [5:0] FN_PWR_DOWN = 6'h08;
  localparam logic [5:0] FN_PWR_UP = 6'h09;
  localparam logic [5:0] FN_MON_SEL = 6'h0A;
  localparam logic [5:0] FN_CTRL = 6'h0C;
  localparam logic [5:0] FN_SOFT_RST = 6'h0F;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CR_PD_MODE = 11;
  localparam int CR_REF_LEVEL = 10;
  localparam int CR_BOOST = 9;
  localparam int CR_REF_EN = 8;
  localparam int CR_MON_EN = 7;
  localparam int CR_THERM_EN = 6;
  localparam int CR_TOGGLE_LSB = 0;
  localparam int MON_FIELD_LSB = 6;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_RESET_BASE = 12'h800;
  localparam logic [11:0] CLEAR_CODE_RESET = 12'h000;
  localparam logic [5:0] MON_HIZ_ADDR = 6'h3F;
  localparam logic [5:0] MON_SEL_RESET = 6'h3F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLEAR_TIME_US = 35;
  localparam int POWER_UP_TIME_US = 8;
  localparam int SOFT_RESET_TIME_US = 135;
  localparam int SHORT_BUSY_NS = 20;
  localparam int CLEAR_CYCLES = (CLEAR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_CYCLES = (POWER_UP_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_BUSY_CYCLES = (SHORT_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: hw/dsc_sync.sv
`timescale 1ns/10ps
module dsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

// file: hw/dsc_busy_timer.sv
`timescale 1ns/10ps
module dsc_busy_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [dsc_pkg::TIMER_W-1:0] length,
  output logic busy_n,
  output logic done
);

  logic [dsc_pkg::TIMER_W-1:0] count;

  // ----------------------------------------------------------------
  // Down counter, busy low while non-zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (start)
      count <= length;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign busy_n = (count == '0);
  assign done = (count == 14'h0001) && !start;

  busy_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && (length != '0) |=> !busy_n)
    else $error("busy did not fall after start");

endmodule

// file: hw/dsc_sfr_ctrl.sv
`timescale 1ns/10ps
// How it works
// - Clear-code write command stores the full data word as the clear code.
// - Clear pin low or soft clear loads every DAC with the clear code.
// - Clear code is all zeros after reset until written.
// - Soft clear ignores data, acts like the pin, busy low for 35 us.
// - Soft power-down ignores data, powers channels down, keeps all registers.
// - While powered down every write except power-down, power-up and soft reset is rejected.
// - In power-down, mode bit 1 gives high impedance, 0 gives pull-down load.
// - Soft power-up ignores data, re-enables amplifiers and reference within 8 us.
// - Effective power-down is hardware input OR software state.
// - Soft reset restores defaults and zeroes all DACs, taking 135 us.
// - Control command writes when read-not-write low, reads back when high.
// - Reference level bit picks 2.5 V at 1, 1.25 V at 0.
// - Boost bit 1 raises amplifier bias, 0 by default keeps it low.
// - Reference enable bit 1 uses internal reference, 0 selects external.
// - Monitor enable turns last channel pin into the monitor output.
// - Thermal enable powers amplifiers down when die is over temperature.
// - After thermal shutdown, power-up re-enables only once die has cooled.
// - Five toggle bits enable toggle mode per group of eight channels.
// - Monitor-select takes channel address from upper six data bits.
// - Monitor address 63 puts the monitor output in high impedance.
// - Commands decoded only when both register selects are zero.
// - No-operation changes nothing but still pulses busy low.
module dsc_sfr_ctrl #(
  parameter bit REF_LEVEL_DEFAULT = 1'b1,
  parameter int SOFT_RESET_CYCLES = dsc_pkg::SOFT_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic register_select_high,
  input wire logic register_select_low,
  input wire logic read_not_write,
  input wire logic [dsc_pkg::FN_W-1:0] function_address_bits,
  input wire logic [dsc_pkg::DATA_W-1:0] data_word_bits,
  input wire logic clear_input_n,
  input wire logic hw_power_down,
  input wire logic die_over_temp,
  output logic busy_n,
  output logic [dsc_pkg::DATA_W-1:0] readback_data,
  output logic readback_valid,
  output logic [dsc_pkg::DATA_W-1:0] control_config,
  output logic [dsc_pkg::DATA_W-1:0] clear_code,
  output logic dac_clear_load,
  output logic dac_reset_all,
  output logic power_down_active,
  output logic outputs_hiz,
  output logic outputs_pulldown,
  output logic amps_enabled,
  output logic thermal_shutdown,
  output logic reference_level_select,
  output logic internal_reference_enable,
  output logic amplifier_boost_enable,
  output logic [dsc_pkg::GROUPS-1:0] group_toggle_enables,
  output logic monitor_enable,
  output logic [dsc_pkg::FN_W-1:0] monitor_channel,
  output logic monitor_hiz
);

  localparam logic [11:0] CTRL_DEFAULT =
    dsc_pkg::CTRL_RESET_BASE | (12'(REF_LEVEL_DEFAULT) << dsc_pkg::CR_REF_LEVEL);

  logic clr_pin_s;
  logic clr_pin_n_s;
  logic hw_pd_s;
  logic over_temp_s;
  logic clr_pin_n_d;
  logic clr_fall;
  logic soft_pd;
  logic pwrup_pending;
  logic accept;
  logic is_clr_code;
  logic is_soft_clear_cmd;
  logic is_pd;
  logic is_pu;
  logic is_mon;
  logic is_ctrl_wr;
  logic is_ctrl_rd;
  logic is_rst;
  logic timer_start;
  logic timer_done;
  logic [dsc_pkg::TIMER_W-1:0] next_length;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Clear pin enters inverted, so a synchroniser in reset reads as an idle pin
  dsc_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({~clear_input_n, hw_power_down, die_over_temp}),
    .sync_out({clr_pin_s, hw_pd_s, over_temp_s})
  );

  assign clr_pin_n_s = !clr_pin_s;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clr_pin_n_d <= 1'b1;
    else
      clr_pin_n_d <= clr_pin_n_s;
  end

  assign clr_fall = clr_pin_n_d && !clr_pin_n_s;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Interface is deaf while busy, so a new word never cuts a timed action short
  assign accept = cmd_valid && busy_n && !register_select_high && !register_select_low;
  assign power_down_active = hw_pd_s || soft_pd;

  // Clear-code, soft clear, monitor and control writes are gated by power-down; power-down, power-up and soft reset are not
  always_comb
  begin
    is_clr_code = 1'b0;
    is_soft_clear_cmd = 1'b0;
    is_pd = 1'b0;
    is_pu = 1'b0;
    is_mon = 1'b0;
    is_ctrl_wr = 1'b0;
    is_ctrl_rd = 1'b0;
    is_rst = 1'b0;
    if (accept)
    begin
      case (function_address_bits)
        dsc_pkg::FN_CLR_CODE: is_clr_code = !read_not_write && !power_down_active;
        dsc_pkg::FN_SOFT_CLEAR_CMD: is_soft_clear_cmd = !read_not_write && !power_down_active;
        dsc_pkg::FN_PWR_DOWN: is_pd = !read_not_write;
        dsc_pkg::FN_PWR_UP: is_pu = !read_not_write;
        dsc_pkg::FN_MON_SEL: is_mon = !read_not_write && !power_down_active;
        dsc_pkg::FN_CTRL:
        begin
          is_ctrl_wr = !read_not_write && !power_down_active;
          is_ctrl_rd = read_not_write;
        end
        dsc_pkg::FN_SOFT_RST: is_rst = !read_not_write;
        default: is_clr_code = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Busy timing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_length = dsc_pkg::TIMER_W'(dsc_pkg::SHORT_BUSY_CYCLES);
    if (is_soft_clear_cmd || (clr_fall && !accept))
      next_length = dsc_pkg::TIMER_W'(dsc_pkg::CLEAR_CYCLES);
    else if (is_pu)
      next_length = dsc_pkg::TIMER_W'(dsc_pkg::POWER_UP_CYCLES);
    else if (is_rst)
      next_length = dsc_pkg::TIMER_W'(SOFT_RESET_CYCLES);
  end

  assign timer_start = accept || (clr_fall && busy_n);

  dsc_busy_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(timer_start),
    .length(next_length),
    .busy_n(busy_n),
    .done(timer_done)
  );

  // ----------------------------------------------------------------
  // Clear code and DAC load strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clear_code <= dsc_pkg::CLEAR_CODE_RESET;
    else if (is_rst)
      clear_code <= dsc_pkg::CLEAR_CODE_RESET;
    else if (is_clr_code)
      clear_code <= data_word_bits;
  end

  // Pin clear is honoured even mid-busy; the strobe is what matters downstream
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_clear_load <= 1'b0;
      dac_reset_all <= 1'b0;
    end
    else
    begin
      dac_clear_load <= is_soft_clear_cmd || clr_fall;
      dac_reset_all <= is_rst;
    end
  end

  // ----------------------------------------------------------------
  // Control register and monitor select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      control_config <= CTRL_DEFAULT;
    else if (is_rst)
      control_config <= CTRL_DEFAULT;
    else if (is_ctrl_wr)
      control_config <= data_word_bits;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      monitor_channel <= dsc_pkg::MON_SEL_RESET;
    else if (is_rst)
      monitor_channel <= dsc_pkg::MON_SEL_RESET;
    else if (is_mon)
      monitor_channel <= data_word_bits[dsc_pkg::MON_FIELD_LSB +: dsc_pkg::FN_W];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readback_data <= '0;
      readback_valid <= 1'b0;
    end
    else
    begin
      readback_valid <= is_ctrl_rd;
      if (is_ctrl_rd)
        readback_data <= control_config;
    end
  end

  assign reference_level_select = control_config[dsc_pkg::CR_REF_LEVEL];
  assign amplifier_boost_enable = control_config[dsc_pkg::CR_BOOST];
  assign internal_reference_enable = control_config[dsc_pkg::CR_REF_EN];
  assign monitor_enable = control_config[dsc_pkg::CR_MON_EN];
  assign group_toggle_enables = control_config[dsc_pkg::CR_TOGGLE_LSB +: dsc_pkg::GROUPS];
  assign monitor_hiz = monitor_enable && (monitor_channel == dsc_pkg::MON_HIZ_ADDR);

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      soft_pd <= 1'b0;
    else if (is_pd)
      soft_pd <= 1'b1;
    else if (is_pu || is_rst)
      soft_pd <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pwrup_pending <= 1'b0;
    else if (is_pu)
      pwrup_pending <= 1'b1;
    else if (timer_done)
      pwrup_pending <= 1'b0;
  end

  // Set wins over the power-up clear while the die is still hot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      thermal_shutdown <= 1'b0;
    else if (control_config[dsc_pkg::CR_THERM_EN] && over_temp_s)
      thermal_shutdown <= 1'b1;
    else if (is_pu && !over_temp_s)
      thermal_shutdown <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      amps_enabled <= 1'b1;
    else
      amps_enabled <= !power_down_active && !thermal_shutdown && !pwrup_pending;
  end

  assign outputs_hiz = power_down_active && control_config[dsc_pkg::CR_PD_MODE];
  assign outputs_pulldown = power_down_active && !control_config[dsc_pkg::CR_PD_MODE];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [dsc_pkg::TIMER_W-1:0] low_count;
  logic [dsc_pkg::TIMER_W-1:0] run_length;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_count <= '0;
      run_length <= '0;
    end
    else if (timer_start)
    begin
      low_count <= '0;
      run_length <= next_length;
    end
    else if (!busy_n)
      low_count <= low_count + 1'b1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_sfr_write(logic [5:0] fn);
    accept && !read_not_write && (function_address_bits == fn);
  endsequence

  clear_code_store_a: assert property (
    s_sfr_write(dsc_pkg::FN_CLR_CODE) and !power_down_active |=> clear_code == $past(data_word_bits))
    else $error("clear code not stored");

  busy_length_a: assert property (
    $rose(busy_n) |-> low_count == run_length)
    else $error("busy low time wrong");

  soft_clear_a: assert property (
    s_sfr_write(dsc_pkg::FN_SOFT_CLEAR_CMD) and !power_down_active |=> dac_clear_load ##1 !busy_n[*8])
    else $error("soft clear not executed");

  pd_reject_a: assert property (
    power_down_active && accept && (function_address_bits != dsc_pkg::FN_SOFT_RST)
    |=> $stable(control_config) && $stable(clear_code))
    else $error("write taken during power-down");

  soft_pd_a: assert property (
    s_sfr_write(dsc_pkg::FN_PWR_DOWN) |=> power_down_active ##1 !amps_enabled)
    else $error("soft power-down ignored");

  ctrl_read_a: assert property (
    accept && read_not_write && function_address_bits == dsc_pkg::FN_CTRL
    |=> readback_valid && readback_data == control_config)
    else $error("control readback wrong");

  mon_hiz_a: assert property (
    s_sfr_write(dsc_pkg::FN_MON_SEL) and !power_down_active and monitor_enable
    and data_word_bits[11:6] == dsc_pkg::MON_HIZ_ADDR |=> monitor_hiz)
    else $error("monitor not high impedance");

  soft_reset_a: assert property (
    s_sfr_write(dsc_pkg::FN_SOFT_RST) |=> control_config == CTRL_DEFAULT && clear_code == 12'h000 && dac_reset_all)
    else $error("soft reset incomplete");

  thermal_off_a: assert property (
    control_config[dsc_pkg::CR_THERM_EN] && over_temp_s |=> ##1 !amps_enabled)
    else $error("thermal shutdown missed");

  nop_keep_a: assert property (
    s_sfr_write(dsc_pkg::FN_NOP) |=> !busy_n && $stable(control_config) && $stable(clear_code))
    else $error("no-operation changed state");

endmodule

// file: testbench/dsc_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host driving the command port
// ----------------------------------------
module dsc_host_model (
  input wire logic clk,
  input wire logic busy_n,
  output logic cmd_valid,
  output logic register_select_high,
  output logic register_select_low,
  output logic read_not_write,
  output logic [dsc_pkg::FN_W-1:0] function_address_bits,
  output logic [dsc_pkg::DATA_W-1:0] data_word_bits
);
  initial
  begin
    cmd_valid = 1'b0;
    {register_select_high, register_select_low} = 2'b11;
    read_not_write = 1'b1;
    function_address_bits = 6'h3f;
    data_word_bits = 12'hfff;
  end

  // Returns busy low time, 0 when the word was not taken
  task automatic send(input logic [1:0] sel, input logic rnw, input logic [5:0] fn,
    input logic [11:0] dat, output int low);
    int i;
    low = 0;
    for (i = 0; i < 20000 && busy_n !== 1'b1; i++)
      @(negedge clk);
    if (busy_n !== 1'b1)
    begin
      low = 20000;
      return;
    end
    @(negedge clk);
    cmd_valid = 1'b1;
    {register_select_high, register_select_low} = sel;
    read_not_write = rnw;
    function_address_bits = fn;
    data_word_bits = dat;
    @(negedge clk);
    // Released lines show the inverse, so a late sample cannot match by luck
    cmd_valid = 1'b0;
    {register_select_high, register_select_low} = ~sel;
    read_not_write = ~rnw;
    function_address_bits = ~fn;
    data_word_bits = ~dat;
    for (i = 0; i < 20000; i++)
    begin
      if (busy_n === 1'b0)
        low++;
      else if (low > 0 || i > 3)
        break;
      @(negedge clk);
    end
  endtask
endmodule

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [1:0] sel;
    logic rnw;
    logic [5:0] fn;
    logic [11:0] dat;
    logic [11:0] ctrl;
    logic [11:0] clr;
    logic [5:0] mon;
    logic [3:0] low;
  } dsc_row_t;

  logic clk, rst_n, clear_input_n, hw_power_down, die_over_temp, cmd_valid, read_not_write;
  logic register_select_high, register_select_low, busy_n, readback_valid, dac_clear_load;
  logic dac_reset_all, power_down_active, outputs_hiz, outputs_pulldown, amps_enabled;
  logic thermal_shutdown, reference_level_select, internal_reference_enable;
  logic amplifier_boost_enable, monitor_enable, monitor_hiz;
  logic [5:0] function_address_bits, monitor_channel;
  logic [11:0] data_word_bits, readback_data, control_config, clear_code, rb;
  logic [4:0] group_toggle_enables;
  int n_errors = 0;
  int num_checks = 0;
  int n_clr = 0;
  int n_rst = 0;
  int i, k;

  // Codes 0c control, 01 clear code, 0a monitor, 00 no-op, 3e unassigned
  dsc_row_t rows [10] = '{
    {2'b00, 1'b0, 6'h0c, 12'h0ff, 12'h0ff, 12'h000, 6'h3f, 4'h2},
    {2'b00, 1'b0, 6'h01, 12'ha5a, 12'h0ff, 12'ha5a, 6'h3f, 4'h2},
    {2'b00, 1'b0, 6'h0a, 12'h140, 12'h0ff, 12'ha5a, 6'h05, 4'h2},
    {2'b00, 1'b0, 6'h00, 12'hfff, 12'h0ff, 12'ha5a, 6'h05, 4'h2},
    {2'b00, 1'b0, 6'h3e, 12'h123, 12'h0ff, 12'ha5a, 6'h05, 4'h2},
    {2'b00, 1'b1, 6'h01, 12'h777, 12'h0ff, 12'ha5a, 6'h05, 4'h2},
    {2'b10, 1'b0, 6'h0c, 12'h000, 12'h0ff, 12'ha5a, 6'h05, 4'h0},
    {2'b01, 1'b0, 6'h01, 12'h000, 12'h0ff, 12'ha5a, 6'h05, 4'h0},
    {2'b00, 1'b0, 6'h0a, 12'hfc0, 12'h0ff, 12'ha5a, 6'h3f, 4'h2},
    {2'b00, 1'b0, 6'h0c, 12'h72a, 12'h72a, 12'ha5a, 6'h3f, 4'h2}
  };

  dsc_sfr_ctrl #(
    .REF_LEVEL_DEFAULT(1'b1),
    .SOFT_RESET_CYCLES(20)
  ) DUT (
    .clk, .rst_n, .cmd_valid, .register_select_high, .register_select_low, .read_not_write,
    .function_address_bits, .data_word_bits, .clear_input_n, .hw_power_down, .die_over_temp,
    .busy_n, .readback_data, .readback_valid, .control_config, .clear_code, .dac_clear_load,
    .dac_reset_all, .power_down_active, .outputs_hiz, .outputs_pulldown, .amps_enabled,
    .thermal_shutdown, .reference_level_select, .internal_reference_enable,
    .amplifier_boost_enable, .group_toggle_enables, .monitor_enable, .monitor_channel, .monitor_hiz
  );

  dsc_host_model host (
    .clk, .busy_n, .cmd_valid, .register_select_high, .register_select_low, .read_not_write,
    .function_address_bits, .data_word_bits
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Strobes are one cycle wide, so they are counted rather than polled
  always @(posedge clk)
  begin
    if (dac_clear_load === 1'b1)
      n_clr++;
    if (dac_reset_all === 1'b1)
      n_rst++;
    if (readback_valid === 1'b1)
      rb = readback_data;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [1:0] sel, input logic rnw, input logic [5:0] fn,
    input logic [11:0] dat, input int exp_low);
    int low;
    host.send(sel, rnw, fn, dat, low);
    check(16'(low), 16'(exp_low));
    if (low >= 20000)
      finish_test();
  endtask

  task automatic wait_amps;
    for (k = 0; k < 10 && amps_enabled !== 1'b1; k++)
      @(negedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    clear_input_n = 1'b1;
    hw_power_down = 1'b0;
    die_over_temp = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    check(control_config, 12'hc00);
    check(clear_code, 12'h000);
    check({busy_n, amps_enabled, monitor_channel}, {2'b11, 6'h3f});
    $display("reset values done");
    // Monitor enable is set in the first row before any channel select
    for (i = 0; i < 10; i++)
    begin
      cmd(rows[i].sel, rows[i].rnw, rows[i].fn, rows[i].dat, int'(rows[i].low));
      check(control_config, rows[i].ctrl);
      check(clear_code, rows[i].clr);
      check(monitor_channel, rows[i].mon);
      check({reference_level_select, amplifier_boost_enable, internal_reference_enable,
        monitor_enable, group_toggle_enables}, {rows[i].ctrl[10:7], rows[i].ctrl[4:0]});
      check(monitor_hiz, rows[i].ctrl[7] && rows[i].mon == 6'h3f);
    end
    $display("table done");
    rb = 12'h000;
    cmd(2'b00, 1'b1, dsc_pkg::FN_CTRL, 12'h000, 2);
    check(rb, 12'h72a);
    $display("readback done");
    k = n_clr;
    cmd(2'b00, 1'b0, dsc_pkg::FN_SOFT_CLEAR_CMD, 12'hfff, 3500);
    check(16'(n_clr - k), 16'h0001);
    check(clear_code, 12'ha5a);
    k = n_clr;
    clear_input_n = 1'b0;
    repeat (6) @(negedge clk);
    clear_input_n = 1'b1;
    check(16'(n_clr - k), 16'h0001);
    $display("clear done");
    cmd(2'b00, 1'b0, dsc_pkg::FN_CTRL, 12'h02a, 2);
    cmd(2'b00, 1'b0, dsc_pkg::FN_PWR_DOWN, 12'hfff, 2);
    check({power_down_active, outputs_pulldown, outputs_hiz}, 3'b110);
    cmd(2'b00, 1'b0, dsc_pkg::FN_CTRL, 12'h0ff, 2);
    cmd(2'b00, 1'b0, dsc_pkg::FN_CLR_CODE, 12'h123, 2);
    check(control_config, 12'h02a);
    check(clear_code, 12'ha5a);
    cmd(2'b00, 1'b0, dsc_pkg::FN_PWR_UP, 12'hfff, 800);
    wait_amps();
    check({power_down_active, amps_enabled}, 2'b01);
    hw_power_down = 1'b1;
    repeat (5) @(negedge clk);
    check({power_down_active, outputs_pulldown}, 2'b11);
    hw_power_down = 1'b0;
    repeat (5) @(negedge clk);
    check(power_down_active, 1'b0);
    $display("power down done");
    cmd(2'b00, 1'b0, dsc_pkg::FN_CTRL, 12'h040, 2);
    die_over_temp = 1'b1;
    repeat (6) @(negedge clk);
    check({thermal_shutdown, amps_enabled}, 2'b10);
    cmd(2'b00, 1'b0, dsc_pkg::FN_PWR_UP, 12'h000, 800);
    repeat (10) @(negedge clk);
    check({thermal_shutdown, amps_enabled}, 2'b10);
    die_over_temp = 1'b0;
    repeat (5) @(negedge clk);
    cmd(2'b00, 1'b0, dsc_pkg::FN_PWR_UP, 12'h000, 800);
    wait_amps();
    check({thermal_shutdown, amps_enabled}, 2'b01);
    $display("thermal done");
    k = n_rst;
    cmd(2'b00, 1'b0, dsc_pkg::FN_SOFT_RST, 12'hfff, 20);
    check(16'(n_rst - k), 16'h0001);
    check(control_config, 12'hc00);
    check({clear_code, monitor_channel}, {12'h000, 6'h3f});
    hw_power_down = 1'b1;
    repeat (5) @(negedge clk);
    check({power_down_active, outputs_pulldown, outputs_hiz}, 3'b101);
    hw_power_down = 1'b0;
    $display("soft reset done");
    finish_test();
  end
endmodule
